// ---- design/dtp_top.sv ----
`timescale 1ns/1ps
`include "dtp_cfg.svh"
module dtp_top (
    input  wire logic                   clk_in,
    input  wire logic                   sys_rst_in,
    input  wire dtp_pkg::dtp_apb_req_type apb_req_in,
    output logic [31:0]                 apb_prdata_out,
    output logic                        apb_pready_out,
    output logic                        apb_pslverr_out,
    input  wire logic                   shared_ext_clock_in,
    input  wire logic [1:0]             port_data_in,
    input  wire logic [1:0]             port_dir_in,
    output logic [1:0]                  pulse_pin_out,
    output logic [1:0]                  pulse_pin_oe_out,
    output logic                        timer_irq_out
);
    import dtp_pkg::*;

    // Address decode shared by read and write paths
    function automatic dtp_reg_type dtp_decode(input logic [9:0] idx);
        logic [1:0] bank;
        logic [4:0] off;
        dtp_reg_type r;
        bank = idx[6:5];
        off  = idx[4:0];
        r    = R_NONE;
        if (idx[9:7] == 3'h0) begin
            case (bank)
                `DTP_BANK_NONE: begin
                    if (off == `DTP_OFF_CPU_STATUS_BITS) r = R_CPU_STATUS_BITS;
                    if (off == `DTP_OFF_CORE_INTERRUPT_STATUS) r = R_CORE_INTERRUPT_STATUS;
                end
                `DTP_BANK_1: begin
                    if (off == `DTP_OFF_PIR) r = R_PIR;
                    if (off == `DTP_OFF_PIE) r = R_PIE;
                end
                `DTP_BANK_2: begin
                    if (off == `DTP_OFF_CNT1) r = R_CNT1;
                    if (off == `DTP_OFF_CNT2) r = R_CNT2;
                    if (off == `DTP_OFF_PER1) r = R_PER1;
                    if (off == `DTP_OFF_PER2) r = R_PER2;
                end
                `DTP_BANK_3: begin
                    if (off == `DTP_OFF_FINE_A) r = R_FINE_A;
                    if (off == `DTP_OFF_FINE_B) r = R_FINE_B;
                    if (off == `DTP_OFF_CRS_A)  r = R_CRS_A;
                    if (off == `DTP_OFF_CRS_B)  r = R_CRS_B;
                    if (off == `DTP_OFF_SETA)   r = R_SETA;
                    if (off == `DTP_OFF_SETB)   r = R_SETB;
                end
                default: r = R_NONE;
            endcase
        end
        return r;
    endfunction

    logic [1:0]   phase_q;
    logic         ext_s1_q;
    logic         ext_s2_q;
    logic         ext_smp_q;
    logic [7:0]   setup_a_q;
    logic [7:0]   setup_b_q;
    logic [7:0]   int_en_q;
    logic         peripheral_int_enable_q;
    logic         gdis_q;
    logic [1:0]   wrap_flag_q;
    logic [7:0]   cnt1_q;
    logic [7:0]   cnt2_q;
    logic [7:0]   per1_q;
    logic [7:0]   per2_q;
    logic         tbsel_q;
    logic [31:0]  prdata_q;
    logic [1:0]   pin_q;
    logic [1:0]   pin_oe_q;
    logic [1:0]   dm_fine_q [2];
    logic [7:0]   dm_crs_q  [2];
    logic [1:0]   ds_fine_q [2];
    logic [7:0]   ds_crs_q  [2];
    logic [1:0]   pwm_q;

    logic         tick;
    logic         ext_fall;
    logic         wr_en;
    logic         rd_setup;
    dtp_reg_type  sel;
    logic [7:0]   wbyte;
    dtp_mode_type mode;
    logic         run1;
    logic         run2;
    logic         src1;
    logic         src2;
    logic         ev1;
    logic         ev2;
    logic         match16;
    logic         wrap1;
    logic         wrap2;
    logic [1:0]   flag_pend;
    logic [31:0]  rdata_d;
    logic [1:0]   pwm_en;

    // APB decode; every access answers in its first access cycle
    assign wr_en    = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite;
    assign rd_setup = apb_req_in.psel & ~apb_req_in.penable & ~apb_req_in.pwrite;
    assign sel      = dtp_decode(apb_req_in.paddr[11:2]);
    assign wbyte    = apb_req_in.pwdata[7:0];
    assign apb_pready_out  = 1'b1;
    assign apb_pslverr_out = apb_req_in.psel & apb_req_in.penable & (sel == R_NONE);
    assign apb_prdata_out  = prdata_q;

    // Quarter-cycle phase; instruction cycle is four oscillator clocks
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            phase_q <= `DTP_Q_ZERO;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end
    assign tick = (phase_q == `DTP_Q_LAST);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ext_s1_q <= 1'b1;
            ext_s2_q <= 1'b1;
        end else begin
            ext_s1_q <= shared_ext_clock_in;
            ext_s2_q <= ext_s1_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ext_smp_q <= 1'b1;
        end else if (phase_q[0]) begin
            ext_smp_q <= ext_s2_q;
        end
    end
    assign ext_fall = phase_q[0] & ext_smp_q & ~ext_s2_q;

    // Control decode
    assign mode = dtp_mode_type'(setup_a_q[`DTP_B_WIDE]);
    assign run1 = setup_b_q[`DTP_B_RUN1];
    assign run2 = setup_b_q[`DTP_B_RUN2];
    assign src1 = setup_a_q[`DTP_B_CS1] ? ext_fall : tick;
    assign src2 = setup_a_q[`DTP_B_CS2] ? ext_fall : tick;
    assign ev1  = run1 & src1;
    assign ev2  = run2 & src2 & (mode == MODE_SPLIT);
    assign match16 = ({cnt2_q, cnt1_q} == {per2_q, per1_q});
    // wrap events; wide wrap only on the first
    assign wrap1 = (mode == MODE_WIDE) ? (ev1 & match16) : (ev1 & (cnt1_q == per1_q));
    assign wrap2 = ev2 & (cnt2_q == per2_q);

    // Low byte; a software write wins over a count
    always_ff @(posedge clk_in) begin
        if (wr_en && sel == R_CNT1) begin
            cnt1_q <= wbyte;
        end else if (wrap1) begin
            cnt1_q <= `DTP_CNT_ZERO;
        end else if (ev1) begin
            cnt1_q <= cnt1_q + 8'h01;
        end
    end

    // High byte: own timer, or carry from the low byte when chained
    always_ff @(posedge clk_in) begin
        if (wr_en && sel == R_CNT2) begin
            cnt2_q <= wbyte;
        // chained high byte needs both run bits
        end else if (mode == MODE_WIDE) begin
            if (wrap1) begin
                cnt2_q <= `DTP_CNT_ZERO;
            end else if (ev1 && run2 && cnt1_q == `DTP_CNT_MAX) begin
                cnt2_q <= cnt2_q + 8'h01;
            end
        end else if (wrap2) begin
            cnt2_q <= `DTP_CNT_ZERO;
        end else if (ev2) begin
            cnt2_q <= cnt2_q + 8'h01;
        end
    end

    // Period registers keep contents across resets
    always_ff @(posedge clk_in) begin
        if (wr_en && sel == R_PER1) begin
            per1_q <= wbyte;
        end
        if (wr_en && sel == R_PER2) begin
            per2_q <= wbyte;
        end
    end

    // control registers clear on every reset
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            setup_a_q <= `DTP_RST_BYTE;
            setup_b_q <= `DTP_RST_BYTE;
        end else begin
            if (wr_en && sel == R_SETA) begin
                setup_a_q <= wbyte;
            end
            if (wr_en && sel == R_SETB) begin
                setup_b_q <= wbyte & `DTP_SETB_MASK;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            int_en_q <= `DTP_RST_BYTE;
            peripheral_int_enable_q   <= 1'b0;
            gdis_q   <= `DTP_RST_GDIS;
        end else begin
            if (wr_en && sel == R_PIE) begin
                int_en_q <= wbyte;
            end
            if (wr_en && sel == R_CORE_INTERRUPT_STATUS) begin
                peripheral_int_enable_q <= wbyte[`DTP_B_PERIPHERAL_INT_ENABLE];
            end
            if (wr_en && sel == R_CPU_STATUS_BITS) begin
                gdis_q <= wbyte[`DTP_B_GDIS];
            end
        end
    end

    // sticky flags; a wrap beats a clearing write
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wrap_flag_q <= 2'h0;
        end else begin
            if (wrap1) begin
                wrap_flag_q[0] <= 1'b1;
            end else if (wr_en && sel == R_PIR) begin
                wrap_flag_q[0] <= wbyte[`DTP_B_IF1];
            end
            if (wrap2) begin
                wrap_flag_q[1] <= 1'b1;
            end else if (wr_en && sel == R_PIR) begin
                wrap_flag_q[1] <= wbyte[`DTP_B_IF2];
            end
        end
    end

    assign flag_pend = wrap_flag_q & {int_en_q[`DTP_B_IF2], int_en_q[`DTP_B_IF1]};
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            timer_irq_out <= 1'b0;
        end else begin
            timer_irq_out <= (|flag_pend) & peripheral_int_enable_q & ~gdis_q;
        end
    end

    // Pulse B time-base select is not double buffered
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tbsel_q <= 1'b0;
        end else if (wr_en && sel == R_FINE_B) begin
            tbsel_q <= wbyte[`DTP_B_TBSEL];
        end
    end

    // enable bits take over the pins
    assign pwm_en = {setup_b_q[`DTP_B_PEN_B], setup_b_q[`DTP_B_PEN_A]};

    // Two pulse channels; only channel B can take the second timer as its time base
    genvar k;
    generate
        for (k = 0; k < 2; k++) begin : g_pwm
            localparam dtp_reg_type FINE_R = (k == 0) ? R_FINE_A : R_FINE_B;
            localparam dtp_reg_type CRS_R  = (k == 0) ? R_CRS_A : R_CRS_B;
            logic       base_wrap;
            logic [7:0] base_cnt;
            logic [9:0] master;
            logic [9:0] slave;

            assign base_wrap = (k == 1 && tbsel_q) ? wrap2 : wrap1;
            assign base_cnt  = (k == 1 && tbsel_q) ? cnt2_q : cnt1_q;
            assign master = {dm_crs_q[k], dm_fine_q[k]};
            assign slave  = {ds_crs_q[k], ds_fine_q[k]};

            // writes land in the master latches
            always_ff @(posedge clk_in) begin
                if (wr_en && sel == FINE_R) begin
                    dm_fine_q[k] <= wbyte[7:6];
                end
                if (wr_en && sel == CRS_R) begin
                    dm_crs_q[k] <= wbyte;
                end
            end

            // slave copied only at period start
            always_ff @(posedge clk_in) begin
                if (base_wrap) begin
                    ds_fine_q[k] <= dm_fine_q[k];
                    ds_crs_q[k]  <= dm_crs_q[k];
                end
            end

            // Output level; glitch free since slave is stable mid-period
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    pwm_q[k] <= 1'b0;
                // period start drives high unless duty zero
                end else if (base_wrap) begin
                    pwm_q[k] <= (master != `DTP_DUTY_ZERO);
                // fall as the phase-extended count reaches duty; high for duty clocks
                end else if ({base_cnt, phase_q} + 10'h001 == slave) begin
                    pwm_q[k] <= 1'b0;
                end
            end

            // pin takeover; direction bit 1 means input
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    pin_q[k]    <= 1'b0;
                    pin_oe_q[k] <= 1'b0;
                end else if (pwm_en[k]) begin
                    pin_q[k]    <= pwm_q[k];
                    pin_oe_q[k] <= 1'b1;
                end else begin
                    pin_q[k]    <= port_data_in[k];
                    pin_oe_q[k] <= ~port_dir_in[k];
                end
            end
        end
    endgenerate
    assign pulse_pin_out    = pin_q;
    assign pulse_pin_oe_out = pin_oe_q;

    // Read mux; duty reads return the slave latches
    always_comb begin
        rdata_d = `DTP_RD_ZERO;
        case (sel)
            R_CPU_STATUS_BITS: rdata_d[`DTP_B_GDIS] = gdis_q;
            R_CORE_INTERRUPT_STATUS: begin
                rdata_d[`DTP_B_PERIPHERAL_INT_ENABLE] = peripheral_int_enable_q;
                rdata_d[`DTP_B_PEIF] = |flag_pend;
            end
            R_PIR: begin
                rdata_d[`DTP_B_IF1] = wrap_flag_q[0];
                rdata_d[`DTP_B_IF2] = wrap_flag_q[1];
            end
            R_PIE:    rdata_d[7:0] = int_en_q;
            R_CNT1:   rdata_d[7:0] = cnt1_q;
            R_CNT2:   rdata_d[7:0] = cnt2_q;
            R_PER1:   rdata_d[7:0] = per1_q;
            R_PER2:   rdata_d[7:0] = per2_q;
            R_FINE_A: rdata_d[7:6] = ds_fine_q[0];
            R_FINE_B: begin
                rdata_d[7:6]          = ds_fine_q[1];
                rdata_d[`DTP_B_TBSEL] = tbsel_q;
            end
            R_CRS_A:  rdata_d[7:0] = ds_crs_q[0];
            R_CRS_B:  rdata_d[7:0] = ds_crs_q[1];
            R_SETA:   rdata_d[7:0] = setup_a_q;
            R_SETB:   rdata_d[7:0] = setup_b_q;
            default:  rdata_d = `DTP_RD_ZERO;
        endcase
    end

    // Read data captured in setup, stable through the access phase
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            prdata_q <= `DTP_RD_ZERO;
        end else if (rd_setup) begin
            prdata_q <= rdata_d;
        end
    end

endmodule

// ---- design/dtp_cfg.svh ----
`ifndef DTP_CFG_SVH
`define DTP_CFG_SVH

// Register index = bank * 32 + offset; byte address = index * 4
`define DTP_OFF_CPU_STATUS_BITS 5'h06
`define DTP_OFF_CORE_INTERRUPT_STATUS 5'h07
`define DTP_OFF_CNT1   5'h10
`define DTP_OFF_CNT2   5'h11
`define DTP_OFF_PER1   5'h14
`define DTP_OFF_PER2   5'h15
`define DTP_OFF_FINE_A 5'h10
`define DTP_OFF_FINE_B 5'h11
`define DTP_OFF_CRS_A  5'h12
`define DTP_OFF_CRS_B  5'h13
`define DTP_OFF_PIR    5'h16
`define DTP_OFF_PIE    5'h17
`define DTP_OFF_SETA   5'h16
`define DTP_OFF_SETB   5'h17
`define DTP_BANK_NONE  2'h0
`define DTP_BANK_1     2'h1
`define DTP_BANK_2     2'h2
`define DTP_BANK_3     2'h3

// Field positions
`define DTP_B_WIDE     3
`define DTP_B_CS1      0
`define DTP_B_CS2      1
`define DTP_B_RUN1     0
`define DTP_B_RUN2     1
`define DTP_B_PEN_A    4
`define DTP_B_PEN_B    5
`define DTP_B_IF1      4
`define DTP_B_IF2      5
`define DTP_B_PERIPHERAL_INT_ENABLE     3
`define DTP_B_PEIF     7
`define DTP_B_GDIS     4
`define DTP_B_TBSEL    5
`define DTP_SETB_MASK  8'h3F

// Reset values and counts
`define DTP_RST_BYTE   8'h00
`define DTP_RST_GDIS   1'b1
`define DTP_Q_LAST     2'h3
`define DTP_Q_ZERO     2'h0
`define DTP_CNT_ZERO   8'h00
`define DTP_CNT_MAX    8'hFF
`define DTP_DUTY_ZERO  10'h000
`define DTP_RD_ZERO    32'h0000_0000

`endif

// ---- design/dtp_pkg.sv ----
package dtp_pkg;

    // APB request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dtp_apb_req_type;

    // Decoded register
    typedef enum logic [3:0] {
        R_NONE   = 4'b0000,
        R_CPU_STATUS_BITS = 4'b0001,
        R_CORE_INTERRUPT_STATUS = 4'b0010,
        R_PIR    = 4'b0011,
        R_PIE    = 4'b0100,
        R_CNT1   = 4'b0101,
        R_CNT2   = 4'b0110,
        R_PER1   = 4'b0111,
        R_PER2   = 4'b1000,
        R_FINE_A = 4'b1001,
        R_FINE_B = 4'b1010,
        R_CRS_A  = 4'b1011,
        R_CRS_B  = 4'b1100,
        R_SETA   = 4'b1101,
        R_SETB   = 4'b1110
    } dtp_reg_type;

    // Timer chaining
    typedef enum logic {
        MODE_SPLIT = 1'b0,
        MODE_WIDE  = 1'b1
    } dtp_mode_type;

endpackage

// ---- sim/dtp_far_side.sv ----
`timescale 1ns/1ps
module dtp_far_side (
    input  wire logic       clk_in,
    input  wire logic [7:0] edges_in,
    input  wire logic [7:0] half_in,
    input  wire logic       go_in,
    input  wire logic [1:0] pin_in,
    input  wire logic [1:0] oe_in,
    output logic            ext_clk_out,
    output logic [8:0]      high_a_out,
    output logic [8:0]      high_b_out,
    output logic            busy_out
);
    int left = 0;
    int ph   = 0;
    int win  = 0;
    // Pulled-up source: idles high, each burst ends high again
    logic clk_q = 1'b1;

    assign ext_clk_out = clk_q;
    assign busy_out    = (left > 0) || (win > 0);

    // Each level lasts half_in+1 cycles; loads count only driven highs
    always @(posedge clk_in) begin
        if (go_in) begin
            left       <= 2 * int'(edges_in);
            ph         <= int'(half_in);
            win        <= 160;
            high_a_out <= 9'h000;
            high_b_out <= 9'h000;
        end else begin
            if (win > 0) begin
                win        <= win - 1;
                high_a_out <= high_a_out + 9'(pin_in[0] & oe_in[0]);
                high_b_out <= high_b_out + 9'(pin_in[1] & oe_in[1]);
            end
            if (left > 0 && ph == 0) begin
                clk_q       <= ~clk_q;
                left        <= left - 1;
                ph          <= int'(half_in);
            end else if (left > 0) begin
                ph <= ph - 1;
            end
        end
    end
endmodule

// ---- sim/dtp_top_sva.sv ----
`timescale 1ns/1ps
module dtp_top_sva (
    input wire logic                     clk_in,
    input wire logic                     sys_rst_in,
    input wire dtp_pkg::dtp_apb_req_type apb_req_in,
    input wire logic [31:0]              apb_prdata_out,
    input wire logic                     apb_pready_out,
    input wire logic                     apb_pslverr_out,
    input wire logic                     shared_ext_clock_in,
    input wire logic [1:0]               port_data_in,
    input wire logic [1:0]               port_dir_in,
    input wire logic [1:0]               pulse_pin_out,
    input wire logic [1:0]               pulse_pin_oe_out,
    input wire logic                     timer_irq_out
);
    import dtp_pkg::*;
    logic       wr;
    logic       cfg_wr;
    logic       gate_open;
    logic [7:0] setb_q;
    logic [1:0] pie_q;
    logic       peripheral_int_enable_q;
    logic       gdis_q;

    // Writes on the interrupt path excuse a change of the request line
    assign wr        = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
    assign cfg_wr    = wr && (apb_req_in.paddr inside {12'h018, 12'h01C, 12'h0D8, 12'h0DC});
    assign gate_open = peripheral_int_enable_q && !gdis_q && (pie_q != 2'b00);

    // Shadow of control bits, taken at the edge the registers take them
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            setb_q <= 8'h00;
            pie_q  <= 2'b00;
            peripheral_int_enable_q <= 1'b0;
            gdis_q <= 1'b1;
        end else if (wr) begin
            if (apb_req_in.paddr == 12'h1DC) setb_q <= apb_req_in.pwdata[7:0];
            if (apb_req_in.paddr == 12'h0DC) pie_q <= apb_req_in.pwdata[5:4];
            if (apb_req_in.paddr == 12'h01C) peripheral_int_enable_q <= apb_req_in.pwdata[3];
            if (apb_req_in.paddr == 12'h018) gdis_q <= apb_req_in.pwdata[4];
        end
    end

    default clocking dtp_cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    property p_oe_a;
        !$past(sys_rst_in) |-> pulse_pin_oe_out[0] == ($past(setb_q[4]) || !$past(port_dir_in[0]));
    endproperty
    a_oe_a: assert property (p_oe_a) else $error("pin a drive wrong");
    property p_oe_b;
        !$past(sys_rst_in) |-> pulse_pin_oe_out[1] == ($past(setb_q[5]) || !$past(port_dir_in[1]));
    endproperty
    a_oe_b: assert property (p_oe_b) else $error("pin b drive wrong");
    property p_port_a;
        !$past(sys_rst_in) && !$past(setb_q[4]) |-> pulse_pin_out[0] == $past(port_data_in[0]);
    endproperty
    a_port_a: assert property (p_port_a) else $error("pin a port level wrong");
    property p_port_b;
        !$past(sys_rst_in) && !$past(setb_q[5]) |-> pulse_pin_out[1] == $past(port_data_in[1]);
    endproperty
    a_port_b: assert property (p_port_b) else $error("pin b port level wrong");
    property p_rst;
        $fell(sys_rst_in) |-> !timer_irq_out && pulse_pin_oe_out == 2'b00 && pulse_pin_out == 2'b00;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_gate;
        timer_irq_out |-> $past(gate_open);
    endproperty
    a_gate: assert property (p_gate) else $error("request with gate closed");
    property p_hold;
        timer_irq_out && !cfg_wr && !$past(cfg_wr) |=> timer_irq_out;
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost without write");
    property p_run;
        $rose(timer_irq_out) |-> $past(cfg_wr, 2) || ($past(setb_q[1:0], 2) != 2'b00);
    endproperty
    a_run: assert property (p_run) else $error("flag set while stopped");

    c_irq: cover property ($rose(timer_irq_out));
    c_pins: cover property (pulse_pin_oe_out == 2'b11 && pulse_pin_out != 2'b00);
    c_err: cover property (apb_pslverr_out);
endmodule

bind dtp_top dtp_top_sva u_sva (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .apb_req_in(apb_req_in),
    .apb_prdata_out(apb_prdata_out), .apb_pready_out(apb_pready_out), .apb_pslverr_out(apb_pslverr_out),
    .shared_ext_clock_in(shared_ext_clock_in), .port_data_in(port_data_in), .port_dir_in(port_dir_in),
    .pulse_pin_out(pulse_pin_out), .pulse_pin_oe_out(pulse_pin_oe_out), .timer_irq_out(timer_irq_out)
);

// ---- sim/dual_timer_with_pwm_outputs_test.sv ----
`timescale 1ns/1ps
module dual_timer_with_pwm_outputs_test;
    import dtp_pkg::*;
    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  d;
        logic [7:0]  r;
        logic        e;
    } dtp_row_type;
    typedef struct packed {
        logic [7:0] ca;
        logic [7:0] fa;
        logic [7:0] cb;
        logic [7:0] fb;
        logic [8:0] ha;
        logic [8:0] hb;
    } dtp_pwm_type;
    // Address, written, read back, error
    localparam dtp_row_type rows [7] = '{'{12'h150, 8'hA5, 8'hA5, 1'b0}, '{12'h154, 8'h3C, 8'h3C, 1'b0},
        '{12'h144, 8'h77, 8'h77, 1'b0}, '{12'h0DC, 8'h30, 8'h30, 1'b0}, '{12'h1DC, 8'hC0, 8'h00, 1'b0},
        '{12'h1D8, 8'h00, 8'h00, 1'b0}, '{12'h3FC, 8'h5A, 8'h00, 1'b1}};
    // Duty bytes and high cycles per 160-cycle window (periods 16 and 32)
    localparam dtp_pwm_type pwms [4] = '{'{8'h01, 8'h80, 8'h02, 8'h20, 9'h03C, 9'h028},
        '{8'h00, 8'h00, 8'h00, 8'h20, 9'h000, 9'h000}, '{8'h04, 8'h00, 8'h08, 8'h20, 9'h0A0, 9'h0A0},
        '{8'h03, 8'hC0, 8'h00, 8'hC0, 9'h096, 9'h01E}};
    logic            clk_in;
    logic            sys_rst_in;
    dtp_apb_req_type req;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    logic            ext_clk;
    logic [1:0]      port_data;
    logic [1:0]      port_dir;
    logic [1:0]      pin;
    logic [1:0]      oe;
    logic            irq;
    logic [7:0]      edges;
    logic [7:0]      half;
    logic            go;
    logic [8:0]      high_a;
    logic [8:0]      high_b;
    logic            busy;
    logic [31:0]     q;
    logic [31:0]     v;
    logic            e;
    int              n_errors = 0;
    int              compares = 0;

    dtp_top dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .apb_req_in(req), .apb_prdata_out(prdata),
        .apb_pready_out(pready), .apb_pslverr_out(pslverr), .shared_ext_clock_in(ext_clk),
        .port_data_in(port_data), .port_dir_in(port_dir), .pulse_pin_out(pin), .pulse_pin_oe_out(oe),
        .timer_irq_out(irq));
    dtp_far_side far (.clk_in(clk_in), .edges_in(edges), .half_in(half), .go_in(go), .pin_in(pin),
        .oe_in(oe), .ext_clk_out(ext_clk), .high_a_out(high_a), .high_b_out(high_b), .busy_out(busy));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic summarize();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer; request held until pready is seen high
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        req <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
        @(posedge clk_in);
        req.penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1) begin
            @(posedge clk_in);
        end
        q = prdata;
        e = pslverr;
        req <= '0;
        @(posedge clk_in);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] x);
        apb(a, 1'b0, 8'h00);
        check(q & {24'hFF_FFFF, m}, {24'h00_0000, x});
    endtask

    // Far-side burst of pin falls plus a 160-cycle load window
    task automatic burst(input logic [7:0] n_edges, input logic [7:0] h);
        edges <= n_edges;
        half  <= h;
        go    <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        @(posedge clk_in);
        while (busy !== 1'b0) begin
            @(posedge clk_in);
        end
    endtask

    initial begin
        req        = '0;
        sys_rst_in = 1'b1;
        port_data  = 2'b00;
        port_dir   = 2'b11;
        edges      = 8'h00;
        half       = 8'h00;
        go         = 1'b0;
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        rd(12'h1D8, 8'hFF, 8'h00);
        rd(12'h1DC, 8'hFF, 8'h00);
        rd(12'h0DC, 8'hFF, 8'h00);
        rd(12'h01C, 8'h08, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            check({31'h0, e}, {31'h0, rows[i].e});
            rd(rows[i].a, 8'hFF, rows[i].r);
            check({31'h0, e}, {31'h0, rows[i].e});
        end
        // First timer alone from the instruction clock, second stopped
        wr(12'h150, 8'h03);
        wr(12'h140, 8'h00);
        wr(12'h144, 8'h00);
        wr(12'h0D8, 8'h00);
        wr(12'h1DC, 8'h01);
        repeat (40) @(posedge clk_in);
        wr(12'h1DC, 8'h00);
        rd(12'h0D8, 8'h30, 8'h10);
        rd(12'h144, 8'hFF, 8'h00);
        apb(12'h140, 1'b0, 8'h00);
        v = q;
        check({31'h0, q[7:0] <= 8'h03}, 32'h0000_0001);
        repeat (20) @(posedge clk_in);
        apb(12'h140, 1'b0, 8'h00);
        check(q, v);
        // Request only with every gate open
        for (int i = 0; i < 4; i++) begin
            wr(12'h01C, {4'h0, i[0], 3'h0});
            wr(12'h018, {3'h0, i[1], 4'h0});
            repeat (2) @(posedge clk_in);
            check({31'h0, irq}, {31'h0, i == 1});
        end
        wr(12'h018, 8'h00);
        wr(12'h0D8, 8'h00);
        repeat (2) @(posedge clk_in);
        check({31'h0, irq}, 32'h0000_0000);
        // Second timer on pin falls, fast then slow source
        wr(12'h154, 8'hFF);
        wr(12'h144, 8'h00);
        wr(12'h1D8, 8'h02);
        wr(12'h1DC, 8'h02);
        burst(8'h05, 8'h03);
        burst(8'h03, 8'h14);
        repeat (12) @(posedge clk_in);
        wr(12'h1DC, 8'h00);
        rd(12'h144, 8'hFF, 8'h08);
        // Chained counter, second source bit set but ignored
        wr(12'h0D8, 8'h00);
        wr(12'h150, 8'h40);
        wr(12'h154, 8'h01);
        wr(12'h140, 8'hF0);
        wr(12'h144, 8'h00);
        wr(12'h1D8, 8'h0A);
        wr(12'h1DC, 8'h01);
        repeat (200) @(posedge clk_in);
        rd(12'h144, 8'hFF, 8'h00);
        wr(12'h140, 8'hF0);
        wr(12'h1DC, 8'h03);
        repeat (200) @(posedge clk_in);
        rd(12'h144, 8'hFF, 8'h01);
        repeat (200) @(posedge clk_in);
        wr(12'h1DC, 8'h00);
        rd(12'h0D8, 8'h30, 8'h10);
        wr(12'h1D8, 8'h00);
        wr(12'h150, 8'h03);
        wr(12'h154, 8'h07);
        wr(12'h140, 8'h00);
        wr(12'h144, 8'h00);
        foreach (pwms[i]) begin
            wr(12'h1C8, pwms[i].ca);
            wr(12'h1C0, pwms[i].fa);
            wr(12'h1CC, pwms[i].cb);
            wr(12'h1C4, pwms[i].fb);
            wr(12'h1DC, 8'h33);
            repeat (100) @(posedge clk_in);
            burst(8'h00, 8'h00);
            check({23'h0, high_a}, {23'h0, pwms[i].ha});
            check({23'h0, high_b}, {23'h0, pwms[i].hb});
            rd(12'h1C8, 8'hFF, pwms[i].ca);
        end
        // Pins return to the port once pulses are off
        wr(12'h1DC, 8'h00);
        port_data <= 2'b10;
        port_dir  <= 2'b01;
        repeat (3) @(posedge clk_in);
        check({30'h0, oe}, 32'h0000_0002);
        check({30'h0, pin}, 32'h0000_0002);
        // Mid-run reset: enables clear, period kept
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_in);
        rd(12'h0DC, 8'hFF, 8'h00);
        rd(12'h150, 8'hFF, 8'h03);
        summarize();
    end

    // Sequence needs about 2300 cycles
    initial begin
        repeat (30000) @(posedge clk_in);
        n_errors++;
        summarize();
    end
endmodule
